// ===== rtl/dce_pkg.sv
// dce_pkg: constants of the disk controller error and status block.
// assumes a single 40 MHz controller clock; no imports anywhere.
package dce_pkg;

  // clock and timing
  localparam int          CLK_KHZ      = 40000;
  localparam int          MT_LIMIT_NS  = 10000;
  localparam int          MT_CYC       = MT_LIMIT_NS * (CLK_KHZ / 1000) / 1000;
  localparam int          CMD_LIMIT_MS = 200;
  localparam int          CMD_CYC      = CMD_LIMIT_MS * CLK_KHZ;

  // error status register bit positions
  localparam int          ES_BUS_RST   = 7;
  localparam int          ES_PARITY    = 8;
  localparam int          ES_DATA      = 9;
  localparam int          ES_BUS_TMO   = 10;
  localparam int          ES_CMD_TMO   = 13;
  localparam int          ES_ST_LO     = 7;
  localparam int          ES_ST_HI     = 15;
  localparam logic [15:0] ES_RESET     = 16'h0000;
  localparam logic [15:0] ES_SELFTEST  = 16'hff80;

  // self-test progress count (command register 2); base value arbitrary
  localparam logic [15:0] PROG_RESET   = 16'hff00;

  // formatted sector header length in words
  localparam logic [15:0] HDR_WORDS    = 16'h0003;

  // trap vectors; zero is fixed, the others are arbitrary
  localparam logic [3:0]  VEC_BUS_RST  = 4'h0;
  localparam logic [3:0]  VEC_ABORT    = 4'h1;
  localparam logic [3:0]  VEC_BUS_TMO  = 4'h2;
  localparam logic [3:0]  VEC_CMD_TMO  = 4'h3;

  // check polynomial x16+x12+x5+1, preset all ones, no final inversion
  localparam logic [15:0] CRC_POLY     = 16'h1021;
  localparam logic [15:0] CRC_INIT     = 16'hffff;

  // master cycle sequencer
  typedef enum logic [3:0] {
    M_IDLE = 4'b0001,
    M_ARB  = 4'b0010,
    M_CYC  = 4'b0100,
    M_DONE = 4'b1000
  } dce_mst_t;

endpackage

// ===== rtl/dce_crc_if.sv
// dce_crc_if: serial read stream between the status block and its checker.
// assumes both ends run on core_clk_i.
`timescale 1ns/1ps
interface dce_crc_if;
  logic start;
  logic bit_vld;
  logic bit_dat;
  logic residue_nz;

  modport checker_end (input start, input bit_vld, input bit_dat,
                       output residue_nz);
  modport user_end    (output start, output bit_vld, output bit_dat,
                       input residue_nz);
endinterface

// ===== rtl/dce_crc_chk.sv
// dce_crc_chk: serial check-character residue over data plus check word.
// assumes start precedes the first bit of each read.
`timescale 1ns/1ps
module dce_crc_chk (
  input  wire logic         core_clk_i,
  input  wire logic         sys_rst_i,
  dce_crc_if.checker_end    crc
);

  logic [15:0] crc_ff;
  logic [15:0] nxt_crc;
  logic        fb;

  always_comb begin
    fb      = crc_ff[15] ^ crc.bit_dat;
    nxt_crc = crc_ff;
    if (crc.start) begin
      nxt_crc = dce_pkg::CRC_INIT;
    end else if (crc.bit_vld) begin
      nxt_crc = {crc_ff[14:0], 1'b0} ^ (fb ? dce_pkg::CRC_POLY : 16'h0000);
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      crc_ff <= dce_pkg::CRC_INIT;
    end else begin
      crc_ff <= nxt_crc;
    end
  end

  // data followed by its own check word leaves zero behind
  assign crc.residue_nz = (crc_ff != 16'h0000);

endmodule // dce_crc_chk

// ===== rtl/dce_err_status.sv
// dce_err_status: bus master watchdog, read check, bus traps, self-test
// status and the error status register of the disk controller.
// assumes command/test strobes come from core_clk_i logic; bus pins async.
`timescale 1ns/1ps

module dce_err_status #(
  parameter int CMD_LIMIT_CYC = dce_pkg::CMD_CYC
) (
  input  wire logic        core_clk_i,
  input  wire logic        sys_rst_i,
  input  wire logic        cmd_start_i,
  input  wire logic        cmd_store_regs_i,
  input  wire logic        cmd_terminate_i,
  input  wire logic        master_req_i,
  input  wire logic        bus_available_i,
  input  wire logic        bus_grant_ack_n_i,
  input  wire logic        bus_stall_n_i,
  input  wire logic        bus_parity_fault_n_i,
  input  wire logic        bus_io_reset_n_i,
  input  wire logic        bus_power_warn_n_i,
  input  wire logic        bus_power_reset_n_i,
  input  wire logic        rd_start_i,
  input  wire logic        rd_bit_vld_i,
  input  wire logic        rd_bit_i,
  input  wire logic        rd_end_i,
  input  wire logic        rd_unfmt_i,
  input  wire logic        rd_fmt_sector_i,
  input  wire logic [15:0] rd_words_i,
  input  wire logic        wr_unfmt_end_i,
  input  wire logic [15:0] wr_words_i,
  input  wire logic        selftest_start_i,
  input  wire logic        selftest_pass_i,
  input  wire logic        selftest_fail_i,
  output logic             bus_cycle_go_n_o,
  output logic             bus_master_term_n_o,
  output logic             master_done_o,
  output logic             interrupt_trap_o,
  output logic [3:0]       trap_vector_o,
  output logic             cmd_abort_o,
  output logic             suspend_o,
  output logic             check_residue_fault_o,
  output logic             fault_led_o,
  output logic             short_test_o,
  output logic [15:0]      cmd_reg2_o,
  output logic [15:0]      error_status_o
);

  localparam int NSYNC  = 6;
  localparam int MT_LIM = dce_pkg::MT_CYC;

  dce_crc_if crc ();

  // async pins: two flops before any logic but the bus_available_i inverter and the power-pin AND; idle level is high
  logic [NSYNC-1:0] pin_raw;
  logic [NSYNC-1:0] sync1_ff;
  logic [NSYNC-1:0] sync2_ff;

  assign pin_raw = {~bus_available_i, bus_grant_ack_n_i, bus_stall_n_i,
                    bus_parity_fault_n_i, bus_io_reset_n_i,
                    bus_power_warn_n_i & bus_power_reset_n_i};

  genvar g;
  generate
    for (g = 0; g < NSYNC; g++) begin : g_sync
      always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
          sync1_ff[g] <= 1'b1;
          sync2_ff[g] <= 1'b1;
        end else begin
          sync1_ff[g] <= pin_raw[g];
          sync2_ff[g] <= sync1_ff[g];
        end
      end
    end
  endgenerate

  logic bus_avail_s;
  logic ack_s;
  logic stall_s;
  logic parity_s;
  logic bus_rst_s;

  assign bus_rst_s   = ~sync2_ff[0] | ~sync2_ff[1];
  assign parity_s    = ~sync2_ff[2];
  assign stall_s     = ~sync2_ff[3];
  assign ack_s       = ~sync2_ff[4];
  assign bus_avail_s = ~sync2_ff[5];

  assign crc.start   = rd_start_i;
  assign crc.bit_vld = rd_bit_vld_i;
  assign crc.bit_dat = rd_bit_i;

  dce_crc_chk u_crc (
    .core_clk_i (core_clk_i),
    .sys_rst_i  (sys_rst_i),
    .crc        (crc)
  );

  dce_pkg::dce_mst_t mst_ff;
  dce_pkg::dce_mst_t nxt_mst;
  logic [8:0]        mt_cnt_ff;
  logic [8:0]        nxt_mt_cnt;
  logic [23:0]       ct_cnt_ff;
  logic [23:0]       nxt_ct_cnt;
  logic              cmd_act_ff;
  logic              nxt_cmd_act;
  logic [15:0]       wr_words_ff;
  logic [15:0]       nxt_wr_words;
  logic [15:0]       status_ff;
  logic [15:0]       nxt_status;
  logic [15:0]       prog_ff;
  logic [15:0]       nxt_prog;
  logic              trap_ff;
  logic              nxt_trap;
  logic [3:0]        vec_ff;
  logic [3:0]        nxt_vec;
  logic              abort_ff;
  logic              nxt_abort;
  logic              led_ff;
  logic              nxt_led;
  logic              short_ff;
  logic              nxt_short;
  logic              done_ff;
  logic              nxt_done;
  logic              suspend_ff;
  logic              nxt_suspend;
  logic              mt_expire;
  logic              ct_expire;
  logic              data_err;

  always_comb begin
    nxt_mst      = mst_ff;
    nxt_mt_cnt   = mt_cnt_ff;
    nxt_ct_cnt   = ct_cnt_ff;
    nxt_cmd_act  = cmd_act_ff;
    nxt_wr_words = wr_words_ff;
    nxt_prog     = prog_ff;
    nxt_trap     = 1'b0;
    nxt_vec      = vec_ff;
    nxt_abort    = 1'b0;
    nxt_led      = led_ff;
    nxt_short    = short_ff;
    nxt_done     = 1'b0;
    nxt_suspend  = 1'b0;
    mt_expire = (mst_ff == dce_pkg::M_ARB || mst_ff == dce_pkg::M_CYC) &&
                (mt_cnt_ff == 9'(dce_pkg::MT_CYC - 1));
    ct_expire = cmd_act_ff && (ct_cnt_ff == 24'(CMD_LIMIT_CYC - 1));
    data_err  = rd_end_i && (crc.residue_nz ||
                (rd_unfmt_i && !rd_fmt_sector_i &&
                 rd_words_i != wr_words_ff) ||
                (rd_unfmt_i && rd_fmt_sector_i &&
                 rd_words_i > dce_pkg::HDR_WORDS));
    // new command clears; any set in the same cycle wins
    nxt_status = cmd_start_i ? dce_pkg::ES_RESET : status_ff;

    if (wr_unfmt_end_i) begin
      nxt_wr_words = wr_words_i;
    end

    case (mst_ff)
      dce_pkg::M_IDLE: begin
        nxt_mt_cnt = 9'h000;
        if (master_req_i) begin
          nxt_mst = dce_pkg::M_ARB;
        end
      end
      dce_pkg::M_ARB: begin
        nxt_mt_cnt = mt_cnt_ff + 9'h001;
        if (bus_avail_s) begin
          nxt_mst = dce_pkg::M_CYC;
        end
      end
      dce_pkg::M_CYC: begin
        nxt_mt_cnt = mt_cnt_ff + 9'h001;
        if (ack_s && !stall_s) begin
          nxt_mst  = dce_pkg::M_DONE;
          nxt_done = 1'b1;
        end
      end
      dce_pkg::M_DONE: begin
        nxt_mst = dce_pkg::M_IDLE;
      end
      default: begin
        nxt_mst = dce_pkg::M_IDLE;
      end
    endcase

    // command timer runs from command start to terminate
    if (cmd_start_i) begin
      nxt_cmd_act = 1'b1;
      nxt_ct_cnt  = 24'h000000;
    end else if (cmd_terminate_i) begin
      nxt_cmd_act = 1'b0;
    end else if (cmd_act_ff) begin
      nxt_ct_cnt = ct_cnt_ff + 24'h000001;
    end

    if (selftest_start_i) begin
      nxt_short = !cmd_store_regs_i;
    end

    // count steps only on a pass
    if (selftest_start_i) begin
      nxt_prog = dce_pkg::PROG_RESET;
    end else if (selftest_pass_i) begin
      nxt_prog = prog_ff + 16'h0001;
    end

    if (data_err) begin
      nxt_status[dce_pkg::ES_DATA] = 1'b1;
    end
    if (selftest_fail_i) begin
      nxt_status = nxt_status | dce_pkg::ES_SELFTEST;
    end

    // clear first so an overrun in the same cycle still lights the lamp
    if (cmd_terminate_i) begin
      nxt_led = 1'b0;
    end
    if (ct_expire) begin
      nxt_status[dce_pkg::ES_CMD_TMO] = 1'b1;
      nxt_led     = 1'b1;
      nxt_cmd_act = 1'b0;
      nxt_trap    = 1'b1;
      nxt_vec     = dce_pkg::VEC_CMD_TMO;
    end

    if (mt_expire && nxt_mst != dce_pkg::M_DONE) begin
      nxt_status[dce_pkg::ES_BUS_TMO] = 1'b1;
      nxt_mst   = dce_pkg::M_IDLE;
      nxt_trap  = 1'b1;
      nxt_vec   = dce_pkg::VEC_BUS_TMO;
      nxt_done  = 1'b0;
    end

    if (parity_s) begin
      nxt_status[dce_pkg::ES_PARITY] = 1'b1;
      nxt_mst     = dce_pkg::M_IDLE;
      nxt_cmd_act = 1'b0;
      nxt_abort   = 1'b1;
      nxt_trap    = 1'b1;
      nxt_vec     = dce_pkg::VEC_ABORT;
      nxt_done    = 1'b0;
    end

    // bus reset traps to zero, highest priority
    if (bus_rst_s) begin
      nxt_status[dce_pkg::ES_BUS_RST] = 1'b1;
      nxt_mst     = dce_pkg::M_IDLE;
      nxt_cmd_act = 1'b0;
      nxt_trap    = 1'b1;
      nxt_vec     = dce_pkg::VEC_BUS_RST;
      nxt_suspend = 1'b1;
      nxt_abort   = 1'b0;
      nxt_done    = 1'b0;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      mst_ff      <= dce_pkg::M_IDLE;
      mt_cnt_ff   <= 9'h000;
      ct_cnt_ff   <= 24'h000000;
      cmd_act_ff  <= 1'b0;
      wr_words_ff <= 16'h0000;
      status_ff   <= dce_pkg::ES_RESET;
      prog_ff     <= dce_pkg::PROG_RESET;
      trap_ff     <= 1'b0;
      vec_ff      <= dce_pkg::VEC_BUS_RST;
      abort_ff    <= 1'b0;
      led_ff      <= 1'b0;
      short_ff    <= 1'b0;
      done_ff     <= 1'b0;
      suspend_ff  <= 1'b0;
    end else begin
      mst_ff      <= nxt_mst;
      mt_cnt_ff   <= nxt_mt_cnt;
      ct_cnt_ff   <= nxt_ct_cnt;
      cmd_act_ff  <= nxt_cmd_act;
      wr_words_ff <= nxt_wr_words;
      status_ff   <= nxt_status;
      prog_ff     <= nxt_prog;
      trap_ff     <= nxt_trap;
      vec_ff      <= nxt_vec;
      abort_ff    <= nxt_abort;
      led_ff      <= nxt_led;
      short_ff    <= nxt_short;
      done_ff     <= nxt_done;
      suspend_ff  <= nxt_suspend;
    end
  end

  // outputs are flops, or one-hot state bits through an inverter or a NOR
  assign bus_cycle_go_n_o      = ~mst_ff[2];
  assign bus_master_term_n_o   = ~(mst_ff[1] | mst_ff[2]);
  assign master_done_o         = done_ff;
  assign interrupt_trap_o      = trap_ff;
  assign trap_vector_o         = vec_ff;
  assign cmd_abort_o           = abort_ff;
  assign suspend_o             = suspend_ff;
  assign check_residue_fault_o = status_ff[dce_pkg::ES_DATA];
  assign fault_led_o           = led_ff;
  assign short_test_o          = short_ff;
  assign cmd_reg2_o            = prog_ff;
  assign error_status_o        = status_ff;

  a_master_window: assert property (
    @(posedge core_clk_i) disable iff (sys_rst_i)
    $rose(mst_ff == dce_pkg::M_ARB) |->
    ##[1:MT_LIM] (mst_ff == dce_pkg::M_IDLE || mst_ff == dce_pkg::M_DONE))
    else $error("master cycle outlived its window");

  a_bus_tmo_report: assert property (
    @(posedge core_clk_i) disable iff (sys_rst_i)
    (mt_expire && !(ack_s && !stall_s && mst_ff == dce_pkg::M_CYC))
    |=> status_ff[dce_pkg::ES_BUS_TMO] && trap_ff &&
        mst_ff == dce_pkg::M_IDLE)
    else $error("bus timeout not reported");

  a_read_check: assert property (
    @(posedge core_clk_i) disable iff (sys_rst_i)
    (rd_end_i && crc.residue_nz && !cmd_start_i)
    |=> status_ff[dce_pkg::ES_DATA])
    else $error("residue fault lost");

  a_unfmt_length: assert property (
    @(posedge core_clk_i) disable iff (sys_rst_i)
    (rd_end_i && rd_unfmt_i && !rd_fmt_sector_i &&
     rd_words_i != wr_words_ff) |=> status_ff[dce_pkg::ES_DATA])
    else $error("unformatted length mismatch missed");

  a_hdr_overrun: assert property (
    @(posedge core_clk_i) disable iff (sys_rst_i)
    (rd_end_i && rd_unfmt_i && rd_fmt_sector_i &&
     rd_words_i > dce_pkg::HDR_WORDS)
    |=> status_ff[dce_pkg::ES_DATA])
    else $error("header overrun missed");

  a_parity_bit: assert property (
    @(posedge core_clk_i) disable iff (sys_rst_i)
    $fell(sync2_ff[2]) |=> status_ff[dce_pkg::ES_PARITY])
    else $error("parity fault not recorded");

  a_parity_abort: assert property (
    @(posedge core_clk_i) disable iff (sys_rst_i)
    (parity_s && !bus_rst_s) |=> cmd_abort_o && !cmd_act_ff)
    else $error("parity fault did not abort");

  a_bus_rst_trap: assert property (
    @(posedge core_clk_i) disable iff (sys_rst_i)
    bus_rst_s |=> trap_ff && vec_ff == 4'h0 && status_ff[dce_pkg::ES_BUS_RST])
    else $error("bus reset trap wrong");

  a_bus_rst_susp: assert property (
    @(posedge core_clk_i) disable iff (sys_rst_i)
    bus_rst_s[*2] |-> suspend_o && mst_ff == dce_pkg::M_IDLE && !cmd_act_ff)
    else $error("operation not suspended");

  a_selftest_fail: assert property (
    @(posedge core_clk_i) disable iff (sys_rst_i)
    selftest_fail_i |=> status_ff[15:7] == 9'h1ff)
    else $error("self-test failure pattern wrong");

  a_progress_step: assert property (
    @(posedge core_clk_i) disable iff (sys_rst_i)
    !selftest_start_i && !selftest_pass_i |=> $stable(cmd_reg2_o))
    else $error("progress moved without a pass");

  a_short_test: assert property (
    @(posedge core_clk_i) disable iff (sys_rst_i)
    (selftest_start_i && !cmd_store_regs_i) |=> short_test_o)
    else $error("short self-test not chosen");

  a_cmd_overrun: assert property (
    @(posedge core_clk_i) disable iff (sys_rst_i)
    $rose(fault_led_o) |-> status_ff[dce_pkg::ES_CMD_TMO])
    else $error("lamp lit without timeout status");

  a_status_hold: assert property (
    @(posedge core_clk_i) disable iff (sys_rst_i)
    !cmd_start_i |=> (($past(status_ff) & ~status_ff) == 16'h0000))
    else $error("status dropped without new command");

endmodule // dce_err_status

// ===== test/dce_bus_host.sv
// dce_bus_host: host memory on the system bus, answering master cycles.
// assumes go_n from the controller; released lines read high (pull-ups).
`timescale 1ns/1ps
module dce_bus_host (
  input  wire logic       core_clk_i,
  input  wire logic       sys_rst_i,
  input  wire logic       go_n_i,
  input  wire logic [1:0] mode_i,
  output logic            bus_available_o,
  output logic            bus_grant_ack_n_o,
  output logic            bus_stall_n_o,
  output logic            bus_parity_fault_n_o
);
  // mode 0 prompt, 1 slow, 2 bus never free, 3 parity fault on the data
  logic [3:0] wait_ff;

  initial begin
    bus_available_o      = 1'b0;
    bus_grant_ack_n_o    = 1'b1;
    bus_stall_n_o        = 1'b1;
    bus_parity_fault_n_o = 1'b1;
  end

  always @(posedge core_clk_i) begin
    bus_available_o <= !sys_rst_i && mode_i != 2'd2;
    if (sys_rst_i || go_n_i) begin
      wait_ff              <= 4'h0;
      bus_grant_ack_n_o    <= 1'b1;
      bus_stall_n_o        <= 1'b1;
      bus_parity_fault_n_o <= 1'b1;
    end else if (mode_i == 2'd1 && wait_ff < 4'h6) begin
      wait_ff       <= wait_ff + 4'h1;
      bus_stall_n_o <= 1'b0;
    end else begin
      bus_grant_ack_n_o    <= 1'b0;
      bus_stall_n_o        <= 1'b1;
      bus_parity_fault_n_o <= mode_i != 2'd3;
    end
  end
endmodule // dce_bus_host

// ===== test/dce_err_status_tb.sv
// dce_err_status_tb: self-checking bench for the error and status block.
// assumes dce_bus_host on the bus side and a 40 MHz core clock.
`timescale 1ns/1ps
module dce_err_status_tb;
  // short command limit keeps the overrun case brief
  localparam int CMD_LIM = 50;
  logic        core_clk_i, sys_rst_i, cmd_start_i, cmd_store_regs_i;
  logic        cmd_terminate_i, master_req_i, bus_available_i;
  logic        bus_grant_ack_n_i, bus_stall_n_i, bus_parity_fault_n_i;
  logic        bus_io_reset_n_i, bus_power_warn_n_i, bus_power_reset_n_i;
  logic        rd_start_i, rd_bit_vld_i, rd_bit_i, rd_end_i, rd_unfmt_i;
  logic        rd_fmt_sector_i, wr_unfmt_end_i, selftest_start_i;
  logic        selftest_pass_i, selftest_fail_i, bus_cycle_go_n_o;
  logic        bus_master_term_n_o, master_done_o, interrupt_trap_o;
  logic        cmd_abort_o, suspend_o, check_residue_fault_o;
  logic        fault_led_o, short_test_o;
  logic [15:0] rd_words_i, wr_words_i, cmd_reg2_o, error_status_o;
  logic [3:0]  trap_vector_o;
  logic [1:0]  host_mode;
  int          n_fail, n_checks;

  dce_err_status #(.CMD_LIMIT_CYC(CMD_LIM)) u_dce_err_status (
    .core_clk_i, .sys_rst_i, .cmd_start_i, .cmd_store_regs_i,
    .cmd_terminate_i, .master_req_i, .bus_available_i, .bus_grant_ack_n_i,
    .bus_stall_n_i, .bus_parity_fault_n_i, .bus_io_reset_n_i,
    .bus_power_warn_n_i, .bus_power_reset_n_i, .rd_start_i, .rd_bit_vld_i,
    .rd_bit_i, .rd_end_i, .rd_unfmt_i, .rd_fmt_sector_i, .rd_words_i,
    .wr_unfmt_end_i, .wr_words_i, .selftest_start_i, .selftest_pass_i,
    .selftest_fail_i, .bus_cycle_go_n_o, .bus_master_term_n_o,
    .master_done_o, .interrupt_trap_o, .trap_vector_o, .cmd_abort_o,
    .suspend_o, .check_residue_fault_o, .fault_led_o, .short_test_o,
    .cmd_reg2_o, .error_status_o);

  dce_bus_host u_dce_bus_host (
    .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i),
    .go_n_i(bus_cycle_go_n_o), .mode_i(host_mode),
    .bus_available_o(bus_available_i), .bus_grant_ack_n_o(bus_grant_ack_n_i),
    .bus_stall_n_o(bus_stall_n_i), .bus_parity_fault_n_o(bus_parity_fault_n_i));

  initial begin
    core_clk_i = 1'b0;
    forever #12.5 core_clk_i = ~core_clk_i;
  end

  task automatic print_verdict();
    if (n_fail == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk16(input string nm, input logic [15:0] e, g);
    n_checks++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch %s exp %h got %h", nm, e, g);
    end
  endtask

  task automatic chk1(input string nm, input logic e, g);
    chk16(nm, {15'h0000, e}, {15'h0000, g});
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk_i);
  endtask

  function automatic logic [15:0] crc_of(input logic [15:0] d);
    logic [15:0] c;
    c = dce_pkg::CRC_INIT;
    for (int i = 15; i >= 0; i--)
      c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? dce_pkg::CRC_POLY : 16'h0000);
    return c;
  endfunction

  // timer stopped at once so only the case under test can trap
  task automatic new_cmd();
    @(posedge core_clk_i) cmd_start_i <= 1'b1;
    @(posedge core_clk_i) begin
      cmd_start_i     <= 1'b0;
      cmd_terminate_i <= 1'b1;
    end
    @(posedge core_clk_i) cmd_terminate_i <= 1'b0;
    tick(2);
  endtask

  // which: 0 done, 1 trap, 2 abort
  task automatic wait_evt(input int which, input int lim, output int cyc);
    logic hit;
    cyc = 0;
    hit = 1'b0;
    while (!hit && cyc < lim) begin
      @(posedge core_clk_i);
      #1;
      cyc++;
      hit = which == 0 ? master_done_o === 1'b1 :
            which == 1 ? interrupt_trap_o === 1'b1 : cmd_abort_o === 1'b1;
    end
    chk1("event_seen", 1'b1, hit);
  endtask

  task automatic master(input logic [1:0] m, input int which, output int cyc);
    @(posedge core_clk_i) host_mode <= m;
    tick(5);
    @(posedge core_clk_i) master_req_i <= 1'b1;
    @(posedge core_clk_i) master_req_i <= 1'b0;
    #1;
    chk1("term_n", 1'b0, bus_master_term_n_o);
    @(posedge core_clk_i);
    #1;
    chk1("go_n", m == 2'd2, bus_cycle_go_n_o);
    wait_evt(which, 600, cyc);
  endtask

  task automatic rd_word(input logic [15:0] d, ck, input logic unf, fmt,
                         input logic [15:0] w);
    logic [31:0] s;
    s = {d, ck};
    @(posedge core_clk_i) begin
      rd_start_i      <= 1'b1;
      rd_unfmt_i      <= unf;
      rd_fmt_sector_i <= fmt;
      rd_words_i      <= w;
    end
    for (int i = 31; i >= 0; i--) begin
      @(posedge core_clk_i) rd_start_i <= 1'b0;
      rd_bit_vld_i <= 1'b1;
      rd_bit_i     <= s[i];
    end
    @(posedge core_clk_i) rd_bit_vld_i <= 1'b0;
    @(posedge core_clk_i) rd_end_i <= 1'b1;
    @(posedge core_clk_i) rd_end_i <= 1'b0;
    tick(2);
    #1;
  endtask

  initial begin
    repeat (20000) @(posedge core_clk_i);
    n_fail++;
    print_verdict();
  end

  initial begin
    int cyc;
    {cmd_start_i, cmd_store_regs_i, cmd_terminate_i, master_req_i} = 4'h0;
    {rd_start_i, rd_bit_vld_i, rd_bit_i, rd_end_i, rd_unfmt_i} = 5'h00;
    {rd_fmt_sector_i, wr_unfmt_end_i, selftest_start_i} = 3'h0;
    {selftest_pass_i, selftest_fail_i} = 2'h0;
    {bus_io_reset_n_i, bus_power_warn_n_i, bus_power_reset_n_i} = 3'h7;
    rd_words_i = 16'h0000;
    wr_words_i = 16'h0000;
    host_mode = 2'd0;
    n_fail = 0;
    n_checks = 0;
    sys_rst_i = 1'b1;
    tick(12);
    sys_rst_i <= 1'b0;
    tick(1);
    #1;
    chk16("error_status", dce_pkg::ES_RESET, error_status_o);
    chk16("cmd_reg2", dce_pkg::PROG_RESET, cmd_reg2_o);
    chk1("go_n", 1'b1, bus_cycle_go_n_o);
    chk1("term_n", 1'b1, bus_master_term_n_o);
    new_cmd();
    master(2'd0, 0, cyc);
    master(2'd1, 0, cyc);
    chk16("error_status", 16'h0000, error_status_o);
    master(2'd2, 1, cyc);
    chk1("tmo_window", 1'b1, cyc >= dce_pkg::MT_CYC - 2 &&
         cyc <= dce_pkg::MT_CYC + 4);
    chk16("vector", 16'(dce_pkg::VEC_BUS_TMO), 16'(trap_vector_o));
    chk1("bus_tmo_bit", 1'b1, error_status_o[dce_pkg::ES_BUS_TMO]);
    tick(2);
    #1;
    chk1("term_n", 1'b1, bus_master_term_n_o);
    tick(20);
    #1;
    chk1("bus_tmo_held", 1'b1, error_status_o[dce_pkg::ES_BUS_TMO]);
    master(2'd0, 0, cyc);
    new_cmd();
    #1;
    chk16("error_status", 16'h0000, error_status_o);
    rd_word(16'ha5c3, crc_of(16'ha5c3), 1'b0, 1'b0, 16'h0001);
    chk1("data_err", 1'b0, error_status_o[dce_pkg::ES_DATA]);
    rd_word(16'ha5c3, crc_of(16'ha5c3) ^ 16'h0001, 1'b0, 1'b0, 16'h0001);
    chk1("data_err", 1'b1, error_status_o[dce_pkg::ES_DATA]);
    chk1("residue_fault", 1'b1, check_residue_fault_o);
    @(posedge core_clk_i) begin
      wr_words_i     <= dce_pkg::HDR_WORDS;
      wr_unfmt_end_i <= 1'b1;
    end
    @(posedge core_clk_i) wr_unfmt_end_i <= 1'b0;
    // bit 1 picks a formatted sector, bit 0 a length over the header
    for (int i = 0; i < 4; i++) begin
      new_cmd();
      rd_word(16'h5a0f, crc_of(16'h5a0f), 1'b1, i[1],
              i[0] ? 16'h0005 : dce_pkg::HDR_WORDS);
      chk1("unfmt_err", i[0], error_status_o[dce_pkg::ES_DATA]);
    end
    new_cmd();
    master(2'd3, 2, cyc);
    tick(1);
    #1;
    chk16("vector", 16'(dce_pkg::VEC_ABORT), 16'(trap_vector_o));
    chk1("parity_bit", 1'b1, error_status_o[dce_pkg::ES_PARITY]);
    @(posedge core_clk_i) host_mode <= 2'd0;
    tick(10);
    for (int i = 0; i < 3; i++) begin
      new_cmd();
      @(posedge core_clk_i) begin
        bus_io_reset_n_i    <= i != 0;
        bus_power_warn_n_i  <= i != 1;
        bus_power_reset_n_i <= i != 2;
      end
      wait_evt(1, 20, cyc);
      chk16("vector", 16'(dce_pkg::VEC_BUS_RST), 16'(trap_vector_o));
      chk1("bus_rst_bit", 1'b1, error_status_o[dce_pkg::ES_BUS_RST]);
      chk1("suspend", 1'b1, suspend_o);
      @(posedge core_clk_i) begin
        bus_io_reset_n_i    <= 1'b1;
        bus_power_warn_n_i  <= 1'b1;
        bus_power_reset_n_i <= 1'b1;
      end
      tick(5);
      #1;
      chk1("suspend", 1'b0, suspend_o);
    end
    for (int i = 0; i < 2; i++) begin
      new_cmd();
      @(posedge core_clk_i) begin
        cmd_store_regs_i <= i[0];
        selftest_start_i <= 1'b1;
      end
      @(posedge core_clk_i) selftest_start_i <= 1'b0;
      tick(1);
      #1;
      chk1("short_test", !i[0], short_test_o);
      chk16("cmd_reg2", dce_pkg::PROG_RESET, cmd_reg2_o);
    end
    repeat (7) begin
      @(posedge core_clk_i) selftest_pass_i <= 1'b1;
      @(posedge core_clk_i) selftest_pass_i <= 1'b0;
    end
    @(posedge core_clk_i) selftest_fail_i <= 1'b1;
    @(posedge core_clk_i) selftest_fail_i <= 1'b0;
    tick(1);
    #1;
    chk16("cmd_reg2", dce_pkg::PROG_RESET + 16'h0007, cmd_reg2_o);
    chk16("st_bits", dce_pkg::ES_SELFTEST,
          error_status_o & dce_pkg::ES_SELFTEST);
    @(posedge core_clk_i) cmd_start_i <= 1'b1;
    @(posedge core_clk_i) cmd_start_i <= 1'b0;
    wait_evt(1, CMD_LIM + 20, cyc);
    chk1("cmd_window", 1'b1, cyc >= CMD_LIM - 2 && cyc <= CMD_LIM + 4);
    chk16("vector", 16'(dce_pkg::VEC_CMD_TMO), 16'(trap_vector_o));
    chk1("cmd_tmo_bit", 1'b1, error_status_o[dce_pkg::ES_CMD_TMO]);
    tick(5);
    #1;
    chk1("fault_led", 1'b1, fault_led_o);
    @(posedge core_clk_i) cmd_terminate_i <= 1'b1;
    @(posedge core_clk_i) cmd_terminate_i <= 1'b0;
    tick(2);
    #1;
    chk1("fault_led", 1'b0, fault_led_o);
    print_verdict();
  end
endmodule // dce_err_status_tb
